// [logic/mac_pkg.sv]
`default_nettype none
package mac_pkg;
  localparam int unsigned MAC_DW = 16;
  localparam int unsigned MAC_AW = 40;
  localparam int unsigned MAC_IW = 24;
  localparam int unsigned MAC_PW = 34;

  // Instruction word layout
  localparam int unsigned MAC_HDR_HI = 23;
  localparam int unsigned MAC_HDR_LO = 19;
  localparam int unsigned MAC_DST_BIT = 18;
  localparam int unsigned MAC_FN_HI = 17;
  localparam int unsigned MAC_FN_LO = 13;
  localparam int unsigned MAC_Y_HI = 12;
  localparam int unsigned MAC_Y_LO = 11;
  localparam int unsigned MAC_X_HI = 10;
  localparam int unsigned MAC_X_LO = 8;
  localparam int unsigned MAC_ZF_HI = 7;
  localparam int unsigned MAC_ZF_LO = 4;
  localparam int unsigned MAC_CND_HI = 3;
  localparam int unsigned MAC_CND_LO = 0;
  localparam logic [4:0] MAC_HDR_VAL = 5'h04;
  localparam logic [3:0] MAC_ZF_VAL = 4'h0;
  localparam logic [3:0] MAC_COND_ALWAYS = 4'hf;

  // Function codes
  localparam logic [4:0] MAC_FN_MUL_SS = 5'h04;
  localparam logic [4:0] MAC_FN_MUL_SU = 5'h05;
  localparam logic [4:0] MAC_FN_MUL_US = 5'h06;
  localparam logic [4:0] MAC_FN_MUL_UU = 5'h07;
  localparam logic [4:0] MAC_FN_MUL_RND = 5'h01;
  localparam logic [4:0] MAC_FN_ACC_SS = 5'h08;
  localparam logic [4:0] MAC_FN_ACC_SU = 5'h09;
  localparam logic [4:0] MAC_FN_ACC_US = 5'h0a;
  localparam logic [4:0] MAC_FN_ACC_UU = 5'h0b;
  localparam logic [4:0] MAC_FN_ACC_RND = 5'h02;

  // Operand selects
  localparam logic [2:0] MAC_X_MX0 = 3'h0;
  localparam logic [2:0] MAC_X_MX1 = 3'h1;
  localparam logic [2:0] MAC_X_AR = 3'h2;
  localparam logic [2:0] MAC_X_MR0 = 3'h3;
  localparam logic [2:0] MAC_X_MR1 = 3'h4;
  localparam logic [2:0] MAC_X_MR2 = 3'h5;
  localparam logic [2:0] MAC_X_SR0 = 3'h6;
  localparam logic [2:0] MAC_X_SR1 = 3'h7;
  localparam logic [1:0] MAC_Y_MY0 = 2'h0;
  localparam logic [1:0] MAC_Y_MY1 = 2'h1;
  localparam logic [1:0] MAC_Y_MF = 2'h2;
  localparam logic [1:0] MAC_Y_ZERO = 2'h3;

  // Rounding and overflow geometry
  localparam logic [39:0] MAC_RND_HALF = 40'h0000008000;
  localparam logic [15:0] MAC_TIE_LOW = 16'h0000;
  localparam int unsigned MAC_RND_BIT = 16;
  localparam int unsigned MAC_FB_HI = 31;
  localparam int unsigned MAC_FB_LO = 16;
  localparam int unsigned MAC_OVF_LO = 31;
  localparam int unsigned MAC_LOW_HI = 15;
  localparam int unsigned MAC_TOP_LO = 32;
  localparam int unsigned MAC_TOP_W = 8;
  localparam int unsigned MAC_FLAG_BIT = 0;

  localparam logic [39:0] MAC_ACC_RST = 40'h0;
  localparam logic [15:0] MAC_FB_RST = 16'h0;
  localparam logic MAC_OVF_RST = 1'b0;

  typedef enum logic [2:0] {
    MAC_OP_NONE = 3'b001,
    MAC_OP_MUL = 3'b010,
    MAC_OP_ACC = 3'b100
  } mac_op_e;
endpackage
`default_nettype wire

// [logic/mac_multiply_accumulate.sv]
// Behaviour
// - On a true predicate, multiply selected x and y and write the destination.
// - False condition leaves accumulator, feedback register and flag untouched.
// - The always-condition code executes regardless of the flag state.
// - Plain multiply into feedback register stores product bits 31-16.
// - Each operand signed or unsigned per format; first letter x, second y.
// - Rounded plain multiply rounds to the top 24 bits, bits 39-16.
// - Rounded plain multiply treats both operands as two's complement.
// - All rounding is unbiased.
// - Overflow flag set when top 9 result bits are not uniform, else cleared.
// - Operands come only from the registers the instruction names.
// - 24-bit word: header 00100, dest, function, y, x, zero nibble, condition.
// - Plain multiply codes 00100 SS, 00101 SU, 00110 US, 00111 UU.
// - Multiply-accumulate adds the product to the 40-bit accumulator.
// - Multiply-accumulate into feedback register stores sum bits 31-16.
// - Rounded accumulate treats operands as signed and rounds the sum.
// - Accumulate codes 01000, 01001, 01010, 01011, and 00010 rounded.
`timescale 1ns/1ps
`default_nettype none
module mac_multiply_accumulate
  import mac_pkg::*;
#(
  parameter int unsigned DW = mac_pkg::MAC_DW
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [mac_pkg::MAC_IW-1:0] instr_i,
  input wire logic cond_true_i,
  input wire logic [DW-1:0] mult_x_input_0_i,
  input wire logic [DW-1:0] mult_x_input_1_i,
  input wire logic [DW-1:0] mult_y_input_0_i,
  input wire logic [DW-1:0] mult_y_input_1_i,
  input wire logic [DW-1:0] alu_result_i,
  input wire logic [DW-1:0] shifter_result_high_i,
  input wire logic [DW-1:0] shifter_result_low_i,
  input wire logic accumulator_top_part_we_i,
  input wire logic accumulator_mid_part_we_i,
  input wire logic accumulator_low_part_we_i,
  input wire logic mac_feedback_reg_we_i,
  input wire logic mac_overflow_flag_we_i,
  input wire logic [DW-1:0] reg_wr_data_i,
  output logic [mac_pkg::MAC_AW-1:0] wide_accumulator_o,
  output logic [DW-1:0] mac_feedback_reg_o,
  output logic mac_overflow_flag_o,
  output logic exec_done_o,
  output logic instr_ignored_o
);
  import mac_pkg::*;

  typedef struct packed {
    logic [MAC_AW-1:0] acc;
    logic [MAC_DW-1:0] fb;
    logic ovf;
    logic done;
    logic ignored;
  } mac_state_s;

  mac_state_s st_q;
  mac_state_s st_d;

  // Operand extended by one bit so one signed multiplier serves all formats
  function automatic logic signed [MAC_DW:0] mac_ext(input logic [MAC_DW-1:0] v,
                                                    input logic sgn);
    mac_ext = {sgn & v[MAC_DW-1], v};
  endfunction

  function automatic logic [MAC_AW-1:0] mac_product(input logic [MAC_DW-1:0] x,
                                                   input logic [MAC_DW-1:0] y,
                                                   input logic xs,
                                                   input logic ys);
    logic signed [MAC_PW-1:0] p;
    p = mac_ext(x, xs) * mac_ext(y, ys);
    mac_product = MAC_AW'(p);
  endfunction

  // Round to nearest at the bit 15/16 boundary, ties to even
  function automatic logic [MAC_AW-1:0] mac_round(input logic [MAC_AW-1:0] v);
    logic [MAC_AW-1:0] r;
    r = v + MAC_RND_HALF;
    if (v[MAC_RND_BIT-1:0] == MAC_RND_HALF[MAC_RND_BIT-1:0]) begin
      r[MAC_RND_BIT] = 1'b0;
    end
    r[MAC_RND_BIT-1:0] = MAC_TIE_LOW;
    mac_round = r;
  endfunction

  function automatic logic mac_ovf(input logic [MAC_AW-1:0] v);
    mac_ovf = ~((&v[MAC_AW-1:MAC_OVF_LO]) | ~(|v[MAC_AW-1:MAC_OVF_LO]));
  endfunction

  logic [4:0] fn;
  logic [2:0] xsel;
  logic [1:0] ysel;
  logic [3:0] cnd;
  logic to_fb;
  logic fmt_ok;
  logic go;
  logic x_sgn;
  logic y_sgn;
  logic rnd;
  mac_op_e op;
  logic [MAC_DW-1:0] xop;
  logic [MAC_DW-1:0] yop;
  logic [MAC_AW-1:0] prod;
  logic [MAC_AW-1:0] res;

  always_comb begin
    fn = instr_i[MAC_FN_HI:MAC_FN_LO];
    xsel = instr_i[MAC_X_HI:MAC_X_LO];
    ysel = instr_i[MAC_Y_HI:MAC_Y_LO];
    cnd = instr_i[MAC_CND_HI:MAC_CND_LO];
    to_fb = instr_i[MAC_DST_BIT];
    fmt_ok = (instr_i[MAC_HDR_HI:MAC_HDR_LO] == MAC_HDR_VAL) &&
             (instr_i[MAC_ZF_HI:MAC_ZF_LO] == MAC_ZF_VAL);
    op = MAC_OP_NONE;
    x_sgn = 1'b1;
    y_sgn = 1'b1;
    rnd = 1'b0;
    // Only explicit format codes execute; there is no default format
    // Every item spells out all four controls so no format leaks between codes
    case (fn)
      MAC_FN_MUL_SS: begin
        op = MAC_OP_MUL;
        x_sgn = 1'b1;
        y_sgn = 1'b1;
        rnd = 1'b0;
      end
      MAC_FN_MUL_SU: begin
        op = MAC_OP_MUL;
        x_sgn = 1'b1;
        y_sgn = 1'b0;
        rnd = 1'b0;
      end
      MAC_FN_MUL_US: begin
        op = MAC_OP_MUL;
        x_sgn = 1'b0;
        y_sgn = 1'b1;
        rnd = 1'b0;
      end
      MAC_FN_MUL_UU: begin
        op = MAC_OP_MUL;
        x_sgn = 1'b0;
        y_sgn = 1'b0;
        rnd = 1'b0;
      end
      MAC_FN_MUL_RND: begin
        op = MAC_OP_MUL;
        x_sgn = 1'b1;
        y_sgn = 1'b1;
        rnd = 1'b1;
      end
      MAC_FN_ACC_SS: begin
        op = MAC_OP_ACC;
        x_sgn = 1'b1;
        y_sgn = 1'b1;
        rnd = 1'b0;
      end
      MAC_FN_ACC_SU: begin
        op = MAC_OP_ACC;
        x_sgn = 1'b1;
        y_sgn = 1'b0;
        rnd = 1'b0;
      end
      MAC_FN_ACC_US: begin
        op = MAC_OP_ACC;
        x_sgn = 1'b0;
        y_sgn = 1'b1;
        rnd = 1'b0;
      end
      MAC_FN_ACC_UU: begin
        op = MAC_OP_ACC;
        x_sgn = 1'b0;
        y_sgn = 1'b0;
        rnd = 1'b0;
      end
      MAC_FN_ACC_RND: begin
        op = MAC_OP_ACC;
        x_sgn = 1'b1;
        y_sgn = 1'b1;
        rnd = 1'b1;
      end
      default: begin
        op = MAC_OP_NONE;
        x_sgn = 1'b1;
        y_sgn = 1'b1;
        rnd = 1'b0;
      end
    endcase
    if (!fmt_ok) begin
      op = MAC_OP_NONE;
    end
    // Always-code bypasses the condition input, not the decoder's verdict
    go = instr_valid_i && (op != MAC_OP_NONE) &&
         ((cnd == MAC_COND_ALWAYS) || cond_true_i);
  end

  // Operand muxes read only the named source registers
  always_comb begin
    if (xsel == MAC_X_MX0) begin
      xop = mult_x_input_0_i;
    end else if (xsel == MAC_X_MX1) begin
      xop = mult_x_input_1_i;
    end else if (xsel == MAC_X_AR) begin
      xop = alu_result_i;
    end else if (xsel == MAC_X_MR0) begin
      xop = st_q.acc[MAC_LOW_HI:0];
    end else if (xsel == MAC_X_MR1) begin
      xop = st_q.acc[MAC_FB_HI:MAC_FB_LO];
    end else if (xsel == MAC_X_MR2) begin
      // Top part is narrow; read back sign-extended
      xop = {{(MAC_DW-MAC_TOP_W){st_q.acc[MAC_AW-1]}}, st_q.acc[MAC_AW-1:MAC_TOP_LO]};
    end else if (xsel == MAC_X_SR0) begin
      xop = shifter_result_low_i;
    end else begin
      xop = shifter_result_high_i;
    end
  end

  always_comb begin
    if (ysel == MAC_Y_MY0) begin
      yop = mult_y_input_0_i;
    end else if (ysel == MAC_Y_MY1) begin
      yop = mult_y_input_1_i;
    end else if (ysel == MAC_Y_MF) begin
      yop = st_q.fb;
    end else begin
      // Zero operand turns accumulate into a plain accumulator transfer
      yop = '0;
    end
  end

  always_comb begin
    prod = mac_product(xop, yop, x_sgn, y_sgn);
    if (op == MAC_OP_ACC) begin
      res = st_q.acc + prod;
    end else begin
      res = prod;
    end
    if (rnd) begin
      res = mac_round(res);
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.ignored = instr_valid_i && !go;
    // Plain register writes from the data bus side
    if (accumulator_low_part_we_i) begin
      st_d.acc[MAC_LOW_HI:0] = reg_wr_data_i;
    end
    if (accumulator_mid_part_we_i) begin
      st_d.acc[MAC_FB_HI:MAC_FB_LO] = reg_wr_data_i;
    end
    if (accumulator_top_part_we_i) begin
      st_d.acc[MAC_AW-1:MAC_TOP_LO] = reg_wr_data_i[MAC_TOP_W-1:0];
    end
    if (mac_feedback_reg_we_i) begin
      st_d.fb = reg_wr_data_i;
    end
    if (mac_overflow_flag_we_i) begin
      st_d.ovf = reg_wr_data_i[MAC_FLAG_BIT];
    end
    // An executing instruction wins over a same-cycle plain write
    if (go) begin
      st_d.done = 1'b1;
      st_d.ovf = mac_ovf(res);
      if (to_fb) begin
        st_d.fb = res[MAC_FB_HI:MAC_FB_LO];
      end else begin
        st_d.acc = res;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q.acc <= MAC_ACC_RST;
      st_q.fb <= MAC_FB_RST;
      st_q.ovf <= MAC_OVF_RST;
      st_q.done <= 1'b0;
      st_q.ignored <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign wide_accumulator_o = st_q.acc;
  assign mac_feedback_reg_o = st_q.fb;
  assign mac_overflow_flag_o = st_q.ovf;
  assign exec_done_o = st_q.done;
  assign instr_ignored_o = st_q.ignored;
endmodule
`default_nettype wire

// [tb/mac_multiply_accumulate_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module mac_multiply_accumulate_chk
  import mac_pkg::*;
#(
  parameter int unsigned DW = 16
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [MAC_IW-1:0] instr_i,
  input wire logic cond_true_i,
  input wire logic [DW-1:0] mult_x_input_0_i,
  input wire logic [DW-1:0] mult_y_input_0_i,
  input wire logic accumulator_low_part_we_i,
  input wire logic [MAC_AW-1:0] wide_accumulator_o,
  input wire logic [DW-1:0] mac_feedback_reg_o,
  input wire logic mac_overflow_flag_o,
  input wire logic exec_done_o,
  input wire logic instr_ignored_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic signed [39:0] prod_q;
  logic signed [39:0] sum_q;
  // Only x and y input 0 with the always-condition are modelled here
  wire logic go = instr_valid_i && instr_i[23:19] == MAC_HDR_VAL && instr_i[12:0] == 13'h000f;
  wire logic skip = instr_valid_i && !cond_true_i && instr_i[3:0] != MAC_COND_ALWAYS;
  always_ff @(posedge sys_clk_i) begin
    prod_q <= $signed(mult_x_input_0_i) * $signed(mult_y_input_0_i);
    sum_q <= $signed(wide_accumulator_o) + $signed(mult_x_input_0_i) * $signed(mult_y_input_0_i);
  end
  sequence s_go(logic [4:0] f, logic d);
    go && instr_i[17:13] == f && instr_i[18] == d;
  endsequence
  sequence s_acc_done;
    instr_valid_i && !instr_i[18] ##1 exec_done_o;
  endsequence
  property p_mul_acc;
    s_go(MAC_FN_MUL_SS, 1'b0) |=> wide_accumulator_o == prod_q && exec_done_o;
  endproperty
  a_mul_acc: assert property (p_mul_acc) else $error("product not in accumulator");
  property p_mul_fb;
    s_go(MAC_FN_MUL_SS, 1'b1) |=> mac_feedback_reg_o == prod_q[31:16] && $stable(wide_accumulator_o);
  endproperty
  a_mul_fb: assert property (p_mul_fb) else $error("feedback product slice wrong");
  property p_mac;
    s_go(MAC_FN_ACC_SS, 1'b0) |=> wide_accumulator_o == sum_q;
  endproperty
  a_mac: assert property (p_mac) else $error("accumulate sum wrong");
  property p_mac_fb;
    s_go(MAC_FN_ACC_SS, 1'b1) |=> mac_feedback_reg_o == sum_q[31:16];
  endproperty
  a_mac_fb: assert property (p_mac_fb) else $error("feedback sum slice wrong");
  property p_ovf;
    s_acc_done |-> mac_overflow_flag_o == !(&wide_accumulator_o[39:31] || !(|wide_accumulator_o[39:31]));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  property p_skip;
    skip && !accumulator_low_part_we_i |=> instr_ignored_o && !exec_done_o
      && $stable(wide_accumulator_o) && $stable(mac_feedback_reg_o) && $stable(mac_overflow_flag_o);
  endproperty
  a_skip: assert property (p_skip) else $error("false condition changed state");
  property p_always;
    s_go(MAC_FN_MUL_UU, 1'b0) ##0 !cond_true_i |=> exec_done_o && !instr_ignored_o;
  endproperty
  a_always: assert property (p_always) else $error("unconditional op not run");
  property p_hdr;
    instr_valid_i && instr_i[23:19] != MAC_HDR_VAL && !accumulator_low_part_we_i
      |=> instr_ignored_o && $stable(wide_accumulator_o);
  endproperty
  a_hdr: assert property (p_hdr) else $error("bad header executed");
endmodule
bind mac_multiply_accumulate mac_multiply_accumulate_chk #(.DW(DW)) u_chk (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .cond_true_i(cond_true_i), .mult_x_input_0_i(mult_x_input_0_i),
  .mult_y_input_0_i(mult_y_input_0_i), .accumulator_low_part_we_i(accumulator_low_part_we_i),
  .wide_accumulator_o(wide_accumulator_o), .mac_feedback_reg_o(mac_feedback_reg_o),
  .mac_overflow_flag_o(mac_overflow_flag_o), .exec_done_o(exec_done_o),
  .instr_ignored_o(instr_ignored_o));
`default_nettype wire

// [tb/mac_tb_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module mac_tb_decoder
  import mac_pkg::*;
(
  input wire logic clk_i,
  output logic valid_o,
  output logic [MAC_IW-1:0] instr_o,
  output logic cond_true_o
);
  initial begin
    valid_o = 1'b0;
    instr_o = 24'h000000;
    cond_true_o = 1'b0;
  end
  task automatic raw(input logic [MAC_IW-1:0] w, input logic t);
    @(negedge clk_i);
    valid_o <= 1'b1;
    instr_o <= w;
    cond_true_o <= t;
  endtask
  task automatic issue(input logic d, input logic [4:0] f, input logic [1:0] y,
                       input logic [2:0] x, input logic [3:0] c, input logic t);
    raw({MAC_HDR_VAL, d, f, y, x, MAC_ZF_VAL, c}, t);
  endtask
  // Released word flips so a stale value is never mistaken for a request
  task automatic idle();
    @(negedge clk_i);
    valid_o <= 1'b0;
    instr_o <= ~instr_o;
    cond_true_o <= ~cond_true_o;
  endtask
endmodule
`default_nettype wire

// [tb/test_mac_multiply_accumulate.sv]
`timescale 1ns/1ps
`default_nettype none
module test_mac_multiply_accumulate;
  import mac_pkg::*;
  logic clk;
  logic rst;
  logic vld;
  logic [23:0] ins;
  logic ct;
  logic wel;
  logic [15:0] src [8];
  logic [39:0] acc;
  logic [15:0] fb;
  logic ovf, done, ign;
  int err_count = 0;
  int compares = 0;
  mac_multiply_accumulate u_dut (
    .sys_clk_i(clk), .sys_rst_i(rst), .instr_valid_i(vld), .instr_i(ins), .cond_true_i(ct),
    .mult_x_input_0_i(src[0]), .mult_x_input_1_i(src[1]), .mult_y_input_0_i(src[2]),
    .mult_y_input_1_i(src[3]), .alu_result_i(src[4]), .shifter_result_high_i(src[5]),
    .shifter_result_low_i(src[6]), .accumulator_top_part_we_i(1'b0),
    .accumulator_mid_part_we_i(1'b0), .accumulator_low_part_we_i(wel),
    .mac_feedback_reg_we_i(1'b0), .mac_overflow_flag_we_i(1'b0), .reg_wr_data_i(src[7]),
    .wide_accumulator_o(acc), .mac_feedback_reg_o(fb), .mac_overflow_flag_o(ovf),
    .exec_done_o(done), .instr_ignored_o(ign));
  mac_tb_decoder u_dec (.clk_i(clk), .valid_o(vld), .instr_o(ins), .cond_true_o(ct));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [39:0] mul(input logic [15:0] x, input logic [15:0] y,
                                      input logic xs, input logic ys);
    logic signed [16:0] a;
    logic signed [16:0] b;
    a = {xs & x[15], x};
    b = {ys & y[15], y};
    return a * b;
  endfunction
  function automatic logic [39:0] rnd(input logic [39:0] v);
    logic [39:0] r;
    r = v + 40'h0000008000;
    if (v[15:0] == 16'h8000) r[16] = 1'b0;
    return {r[39:16], 16'h0000};
  endfunction
  task automatic run(input logic d, input logic [4:0] f, input logic [1:0] y,
                     input logic [2:0] x, input logic [3:0] c, input logic t);
    u_dec.issue(d, f, y, x, c, t);
    u_dec.idle();
  endtask
  task automatic t_formats();
    logic [39:0] e;
    for (int i = 0; i < 4; i++) begin
      e = mul(src[0], src[2], !i[1], !i[0]);
      run(1'b0, MAC_FN_MUL_SS + 5'(i), 2'h0, 3'h0, 4'hf, 1'b0);
      chk(acc, e);
      chk(40'(ovf), 40'(!(&e[39:31] || !(|e[39:31]))));
    end
    e = acc;
    // Back to back, each result feeds the next
    for (int i = 0; i < 4; i++) begin
      e = e + mul(src[0], src[2], !i[1], !i[0]);
      u_dec.issue(1'b0, MAC_FN_ACC_SS + 5'(i), 2'h0, 3'h0, 4'hf, 1'b0);
    end
    u_dec.idle();
    chk(acc, e);
  endtask
  task automatic t_sources();
    logic [15:0] xv [8];
    logic [39:0] e;
    logic [39:0] p;
    @(negedge clk) wel = 1'b1;
    @(negedge clk) wel = 1'b0;
    xv = '{src[0], src[1], src[4], acc[15:0], acc[31:16], {{8{acc[39]}}, acc[39:32]}, src[6], src[5]};
    e = acc;
    for (int i = 0; i < 8; i++) begin
      p = mul(xv[i], src[3], 1'b1, 1'b1);
      run(1'b1, MAC_FN_MUL_SS, 2'h1, 3'(i), 4'hf, 1'b1);
      chk(40'(fb), 40'(p[31:16]));
      chk(acc, e);
    end
    for (int j = 0; j < 3; j += 2) begin
      p = acc + mul(src[0], (j != 0) ? fb : src[2], 1'b1, 1'b1);
      run(1'b1, MAC_FN_ACC_SS, 2'(j), 3'h0, 4'hf, 1'b1);
      chk(40'(fb), 40'(p[31:16]));
    end
  endtask
  task automatic t_rnd(input logic [15:0] x, input logic [15:0] y, input logic [4:0] f);
    logic [39:0] e;
    src[0] = x;
    src[2] = y;
    e = rnd(((f == MAC_FN_ACC_RND) ? acc : 40'h0) + mul(x, y, 1'b1, 1'b1));
    run(1'b0, f, 2'h0, 3'h0, 4'hf, 1'b1);
    chk(acc, e);
  endtask
  task automatic t_cond();
    logic [39:0] e;
    logic [15:0] f;
    e = acc;
    f = fb;
    run(1'b0, MAC_FN_ACC_SS, 2'h0, 3'h0, 4'h0, 1'b0);
    chk(40'(ign), 40'h1);
    chk({acc[39:16], fb}, {e[39:16], f});
    u_dec.raw({5'h0c, 1'b0, MAC_FN_MUL_SS, 13'h000f}, 1'b1);
    u_dec.idle();
    chk({acc, ign}, {e, 1'b1});
    u_dec.raw({MAC_HDR_VAL, 1'b0, 5'h1f, 13'h000f}, 1'b1);
    u_dec.idle();
    chk({acc, ign, done}, {e, 2'b10});
    u_dec.raw({MAC_HDR_VAL, 1'b0, MAC_FN_MUL_SS, 13'h001f}, 1'b1);
    u_dec.idle();
    chk({acc, ign, done}, {e, 2'b10});
    run(1'b0, MAC_FN_MUL_SS, 2'h0, 3'h0, 4'h0, 1'b1);
    chk(acc, mul(src[0], src[2], 1'b1, 1'b1));
    chk(40'({done, ign}), 40'h2);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    wel = 1'b0;
    src = '{16'hffff, 16'h1234, 16'hffff, 16'h8001, 16'h7ffe, 16'hc003, 16'h00ff, 16'h5a5a};
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_formats();
    t_sources();
    t_rnd(16'hffff, 16'h4001, MAC_FN_MUL_RND);
    t_rnd(16'h0003, 16'h8000, MAC_FN_MUL_RND);
    t_rnd(16'hffff, 16'h8000, MAC_FN_ACC_RND);
    t_cond();
    end_of_test();
  end
  // About 70 cycles expected; generous margin
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
